// ### dfs_supervisor.sv
/*
 * dfs_supervisor: fault supervision and parameter protection of a frequency converter.
 * Assumes all inputs synchronous to clk_sys_i and a parameter store outside that
 * acts on par_ack_o / factory_load_o and feeds the configuration back on cfg_i.
 */
// Overview of operation
// R1 - link silence picks one of five responses; factory choice is none
// R2 - last-average response warns and holds the mean output of the last ten seconds
// R3 - link counts as lost once silence exceeds tolerance 0..600 s, factory 30 s
// R4 - keypad watched only for keypad referencing; same responses, factory stop
// R5 - keypad lost once absence exceeds tolerance 0..300 s, factory 30 s
// R6 - warning keeps reference frequency; preset-seven mode runs at preset seven
// R7 - selected digital input clears latched failure; none selected disables it
// R8 - up to 0..6 automatic restarts per window, each after a programmed delay
// R9 - restart only for failure types whose own enable is on; all off at factory
// R10 - sixteen-entry read-only history, entry one newest, sixteen oldest
// R11 - each history entry carries its hour stamp beside the failure code
// R12 - parameter lock rejects every modification until it is cleared
// R13 - access field reads level 0..2; writing a code 0..9999 sets the level
// R14 - code of the currently held level may be replaced by 0..9999
// R15 - factory load needs highest level and is refused while running
// R16 - a stopping failure latches, enters history newest and holds stop until cleared
`timescale 1ns/1ps
`default_nettype none

module dfs_supervisor
    import dfs_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_DS_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire dfs_cfg_t cfg_i,
    input wire logic [FREQ_W-1:0] ref_freq_i,
    input wire logic [FREQ_W-1:0] preset_seven_freq_i,
    input wire logic link_activity_i,
    input wire logic key_ref_sel_i,
    input wire logic key_present_i,
    input wire logic [DIN_N-1:0] digital_input_line_i,
    input wire logic fail_i,
    input wire dfs_fail_t fail_code_i,
    input wire logic running_i,
    input wire dfs_par_req_t par_req_i,
    input wire logic [3:0] hist_idx_i,
    output logic [FREQ_W-1:0] freq_o,
    output logic warn_o,
    output logic stop_o,
    output logic fault_o,
    output dfs_fail_t fault_code_o,
    output logic link_lost_o,
    output logic key_lost_o,
    output logic restart_o,
    output dfs_hist_t hist_o,
    output logic param_lock_o,
    output dfs_level_t access_level_o,
    output logic par_ack_o,
    output logic par_rej_o,
    output logic factory_load_o
);

    localparam int unsigned TICK_W = $clog2(TICK_CYC);
    localparam int unsigned ACC_W = FREQ_W + 4;

    if (TICK_CYC < 2) begin : g_chk
        $error("TICK_CYC must be at least 2");
    end

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic [3:0] ds_cnt;
        logic [15:0] hour_ds;
        logic [HOURS_W-1:0] hours;
        logic [9:0] link_sil_s;
        logic [8:0] key_abs_s;
        logic link_tripped;
        logic key_tripped;
        logic [ACC_W-1:0] sec_acc;
        logic [AVG_WIN_S-1:0][FREQ_W-1:0] ring;
        logic [3:0] ring_ptr;
        logic [ACC_W-1:0] ring_sum;
        logic [DIN_N-1:0] din_prev;
        logic ar_wait;
        logic [6:0] delay_cnt;
        logic win_active;
        logic [13:0] win_cnt;
        logic [2:0] attempts;
        dfs_hist_t [HIST_N-1:0] hist;
        logic [13:0] code_mid;
        logic [13:0] code_high;
        logic [FREQ_W-1:0] freq;
        logic warn;
        logic stop;
        logic fault;
        dfs_fail_t fault_code;
        logic link_lost;
        logic key_lost;
        logic restart;
        dfs_hist_t hist_rd;
        logic lock;
        dfs_level_t level;
        logic par_ack;
        logic par_rej;
        logic factory_load;
    } dfs_state_t;

    dfs_state_t s_q;
    dfs_state_t s_d;

    logic tick;
    logic sec;
    logic link_lost_now;
    logic key_lost_now;
    logic ev;
    dfs_fail_t ev_code;
    logic ev_ar_en;
    logic ext_clr;
    dfs_resp_t act_resp;
    logic [ACC_W-1:0] acc_new;
    logic [FREQ_W-1:0] sec_avg;
    logic [FREQ_W-1:0] avg_freq;
    logic hold_avg;

    always_comb begin
        s_d = s_q;
        s_d.restart = 1'b0;
        s_d.par_ack = 1'b0;
        s_d.par_rej = 1'b0;
        s_d.factory_load = 1'b0;

        // time base: tenth-second tick, seconds and hour stamp
        tick = (s_q.tick_cnt == TICK_W'(TICK_CYC - 1));
        sec = tick && (s_q.ds_cnt == 4'(DS_PER_S - 1));
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + TICK_W'(1);
        if (tick) begin
            s_d.ds_cnt = sec ? 4'h0 : s_q.ds_cnt + 4'h1;
            if (s_q.hour_ds == 16'(HOUR_DS - 1)) begin
                s_d.hour_ds = 16'h0000;
                s_d.hours = s_q.hours + HOURS_W'(1);
            end else begin
                s_d.hour_ds = s_q.hour_ds + 16'h0001;
            end
        end

        // link silence, saturating so a long outage never wraps to "alive"
        if (link_activity_i) begin
            s_d.link_sil_s = 10'h000;
        end else if (sec && s_q.link_sil_s != 10'h3FF) begin
            s_d.link_sil_s = s_q.link_sil_s + 10'h001;
        end
        link_lost_now = (s_q.link_sil_s > cfg_i.link_tol_s); // [R3]

        // keypad absence only counts while the keypad is the reference source
        if (!key_ref_sel_i || key_present_i) begin // [R4]
            s_d.key_abs_s = 9'h000;
        end else if (sec && s_q.key_abs_s != 9'h1FF) begin
            s_d.key_abs_s = s_q.key_abs_s + 9'h001;
        end
        key_lost_now = key_ref_sel_i && (s_q.key_abs_s > cfg_i.key_tol_s); // [R5]
        s_d.link_lost = link_lost_now;
        s_d.key_lost = key_lost_now;

        // failure events; an external failure goes first, a supervision trip waits for the next cycle without one
        ev = 1'b0;
        ev_code = FAIL_NONE;
        if (!link_lost_now) begin
            s_d.link_tripped = 1'b0;
        end
        if (!key_lost_now) begin
            s_d.key_tripped = 1'b0;
        end
        if (fail_i) begin
            ev = 1'b1;
            ev_code = fail_code_i;
        end else if (link_lost_now && cfg_i.link_resp == RESP_FAIL && !s_q.link_tripped) begin
            ev = 1'b1; // [R1]
            ev_code = FAIL_LINK_LOST;
            s_d.link_tripped = 1'b1;
        end else if (key_lost_now && cfg_i.key_resp == RESP_FAIL && !s_q.key_tripped) begin
            ev = 1'b1; // [R4]
            ev_code = FAIL_KEYPAD_LOST;
            s_d.key_tripped = 1'b1;
        end

        unique case (ev_code)
            FAIL_LOW_DC: ev_ar_en = cfg_i.ar_enable[AR_EN_LOW_DC]; // [R9]
            FAIL_HIGH_DC: ev_ar_en = cfg_i.ar_enable[AR_EN_HIGH_DC];
            FAIL_OVERCURRENT: ev_ar_en = cfg_i.ar_enable[AR_EN_OVERCURRENT];
            FAIL_HEATSINK: ev_ar_en = cfg_i.ar_enable[AR_EN_HEATSINK];
            FAIL_ANALOG: ev_ar_en = cfg_i.ar_enable[AR_EN_ANALOG];
            default: ev_ar_en = 1'b0;
        endcase

        // external clear on the rising edge of the selected input line
        s_d.din_prev = digital_input_line_i;
        ext_clr = 1'b0;
        if (cfg_i.digital_input_source_select != SOURCE_DISABLED
            && cfg_i.digital_input_source_select <= 3'(DIN_N)) begin // [R7]
            ext_clr = digital_input_line_i[cfg_i.digital_input_source_select - 3'h1]
                && !s_q.din_prev[cfg_i.digital_input_source_select - 3'h1];
        end
        if (ext_clr) begin
            s_d.fault = 1'b0; // [R7]
            s_d.ar_wait = 1'b0;
        end

        // restart window: the attempt budget refills when the window runs out
        if (s_q.win_active && tick) begin
            if (s_q.win_cnt >= cfg_i.ar_window_ds) begin // [R8]
                s_d.win_active = 1'b0;
                s_d.attempts = 3'h0;
                s_d.win_cnt = 14'h0000;
            end else begin
                s_d.win_cnt = s_q.win_cnt + 14'h0001;
            end
        end

        // restart delay, then release the latched failure
        if (s_q.ar_wait && s_q.fault && !ext_clr && tick) begin
            if (s_q.delay_cnt >= cfg_i.ar_delay_ds) begin // [R8]
                s_d.ar_wait = 1'b0;
                s_d.fault = 1'b0;
                s_d.restart = 1'b1;
                s_d.attempts = s_q.attempts + 3'h1;
                if (!s_q.win_active) begin
                    s_d.win_active = 1'b1;
                    s_d.win_cnt = 14'h0000;
                end
            end else begin
                s_d.delay_cnt = s_q.delay_cnt + 7'h01;
            end
        end

        // a new failure wins over a clear or a restart in the same cycle
        if (ev) begin
            s_d.fault = 1'b1; // [R16]
            s_d.fault_code = ev_code;
            s_d.restart = 1'b0;
            for (int i = HIST_N - 1; i > 0; i--) begin
                s_d.hist[i] = s_q.hist[i-1]; // [R10]
            end
            s_d.hist[0] = '{code: ev_code, hours: s_q.hours}; // [R11]
            s_d.ar_wait = ev_ar_en && cfg_i.ar_count != 3'h0
                && s_d.attempts < cfg_i.ar_count; // [R8] [R9]
            s_d.delay_cnt = 7'h00;
        end
        s_d.hist_rd = s_q.hist[hist_idx_i]; // [R10] [R11]

        // active response: link loss outranks keypad loss
        if (link_lost_now) begin
            act_resp = cfg_i.link_resp;
        end else if (key_lost_now) begin
            act_resp = cfg_i.key_resp;
        end else begin
            act_resp = RESP_NONE;
        end
        hold_avg = (act_resp == RESP_LAST_AVG);

        // ten-second mean built from ten one-second means; frozen while it is in use
        avg_freq = FREQ_W'(s_q.ring_sum / ACC_W'(AVG_WIN_S));
        acc_new = s_q.sec_acc + ACC_W'(s_q.freq);
        sec_avg = FREQ_W'(acc_new / ACC_W'(DS_PER_S));
        if (tick && !hold_avg) begin // [R2]
            s_d.sec_acc = acc_new;
            if (sec) begin
                s_d.sec_acc = '0;
                s_d.ring[s_q.ring_ptr] = sec_avg;
                s_d.ring_sum = s_q.ring_sum - ACC_W'(s_q.ring[s_q.ring_ptr])
                    + ACC_W'(sec_avg);
                s_d.ring_ptr = (s_q.ring_ptr == 4'(AVG_WIN_S - 1)) ? 4'h0
                    : s_q.ring_ptr + 4'h1;
            end
        end

        s_d.warn = 1'b0;
        s_d.stop = 1'b0;
        s_d.freq = ref_freq_i;
        if (s_d.fault) begin
            s_d.stop = 1'b1; // [R16]
            s_d.freq = '0;
        end else begin
            unique case (act_resp)
                RESP_NONE: s_d.freq = ref_freq_i; // [R1]
                RESP_WARN: s_d.warn = 1'b1; // [R6]
                RESP_FAIL: begin
                    s_d.stop = 1'b1;
                    s_d.freq = '0;
                end
                RESP_LAST_AVG: begin
                    s_d.warn = 1'b1; // [R2]
                    s_d.freq = avg_freq;
                end
                RESP_PRESET_SEVEN_FREQUENCY_MODE: s_d.freq = preset_seven_freq_i; // [R6]
                default: s_d.freq = ref_freq_i;
            endcase
        end

        // parameter access
        if (par_req_i.valid) begin
            s_d.par_ack = 1'b1;
            unique case (par_req_i.field)
                PF_LOCK: s_d.lock = par_req_i.data[0]; // [R12]
                PF_ACCESS: begin
                    if (par_req_i.data > CODE_MAX) begin // [R13]
                        s_d.par_ack = 1'b0;
                        s_d.par_rej = 1'b1;
                    end else if (par_req_i.data == s_q.code_high) begin
                        s_d.level = HIGHEST_ACCESS_LEVEL;
                    end else if (par_req_i.data == s_q.code_mid) begin
                        s_d.level = MIDDLE_ACCESS_LEVEL;
                    end else begin
                        s_d.level = LOWEST_ACCESS_LEVEL;
                    end
                end
                PF_NEW_CODE: begin
                    if (s_q.lock || par_req_i.data > CODE_MAX
                        || s_q.level == LOWEST_ACCESS_LEVEL) begin // [R14] [R12]
                        s_d.par_ack = 1'b0;
                        s_d.par_rej = 1'b1;
                    end else if (s_q.level == HIGHEST_ACCESS_LEVEL) begin
                        s_d.code_high = par_req_i.data;
                    end else begin
                        s_d.code_mid = par_req_i.data;
                    end
                end
                PF_FACTORY: begin
                    if (s_q.lock || s_q.level != HIGHEST_ACCESS_LEVEL || running_i) begin // [R15]
                        s_d.par_ack = 1'b0;
                        s_d.par_rej = 1'b1;
                    end else begin
                        s_d.factory_load = 1'b1;
                    end
                end
                PF_OTHER: begin
                    if (s_q.lock) begin // [R12]
                        s_d.par_ack = 1'b0;
                        s_d.par_rej = 1'b1;
                    end
                end
                default: begin
                    s_d.par_ack = 1'b0;
                    s_d.par_rej = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.code_mid <= CODE_MID_RST;
            s_q.code_high <= CODE_HIGH_RST;
            s_q.stop <= 1'b1;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign freq_o = s_q.freq;
    assign warn_o = s_q.warn;
    assign stop_o = s_q.stop;
    assign fault_o = s_q.fault;
    assign fault_code_o = s_q.fault_code;
    assign link_lost_o = s_q.link_lost;
    assign key_lost_o = s_q.key_lost;
    assign restart_o = s_q.restart;
    assign hist_o = s_q.hist_rd;
    assign param_lock_o = s_q.lock;
    assign access_level_o = s_q.level;
    assign par_ack_o = s_q.par_ack;
    assign par_rej_o = s_q.par_rej;
    assign factory_load_o = s_q.factory_load;

endmodule // dfs_supervisor

`default_nettype wire

// ### dfs_pkg.sv
/*
 * dfs_pkg: shared constants, encodings and carrier types of the drive fault supervisor.
 * Assumes one 20 MHz system clock; every time below is given in its own unit
 * and turned into cycles inside the supervisor.
 */
`default_nettype none

package dfs_pkg;

    // time base
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned DS_PER_S = 10;
    localparam int unsigned TICK_DS_CYC = CLK_HZ / DS_PER_S;
    localparam int unsigned AVG_WIN_S = 10;
    localparam int unsigned HOUR_S = 3600;
    localparam int unsigned HOUR_DS = HOUR_S * DS_PER_S;

    // programmable ranges
    localparam int unsigned LINK_TOL_MAX_S = 600;
    localparam int unsigned KEY_TOL_MAX_S = 300;
    localparam int unsigned AR_MAX = 6;
    localparam int unsigned AR_WIN_MAX_DS = 12000;
    localparam int unsigned AR_DELAY_MAX_DS = 100;
    localparam logic [13:0] CODE_MAX = 14'h270F;
    localparam int unsigned HIST_N = 16;
    localparam int unsigned FREQ_W = 16;
    localparam int unsigned HOURS_W = 16;
    localparam int unsigned DIN_N = 6;

    typedef enum logic [2:0] {
        RESP_NONE = 3'h0,
        RESP_WARN = 3'h1,
        RESP_FAIL = 3'h2,
        RESP_LAST_AVG = 3'h3,
        RESP_PRESET_SEVEN_FREQUENCY_MODE = 3'h4
    } dfs_resp_t;

    typedef enum logic [4:0] {
        FAIL_NONE = 5'h00,
        FAIL_LOW_DC = 5'h01,
        FAIL_HIGH_DC = 5'h02,
        FAIL_OVERCURRENT = 5'h03,
        FAIL_HEATSINK = 5'h04,
        FAIL_ANALOG = 5'h05,
        FAIL_LINK_LOST = 5'h06,
        FAIL_KEYPAD_LOST = 5'h07,
        FAIL_OTHER = 5'h08
    } dfs_fail_t;

    typedef enum logic [1:0] {
        LOWEST_ACCESS_LEVEL = 2'h0,
        MIDDLE_ACCESS_LEVEL = 2'h1,
        HIGHEST_ACCESS_LEVEL = 2'h2
    } dfs_level_t;

    typedef enum logic [2:0] {
        PF_LOCK = 3'h0,
        PF_ACCESS = 3'h1,
        PF_NEW_CODE = 3'h2,
        PF_FACTORY = 3'h3,
        PF_OTHER = 3'h4
    } dfs_field_t;

    // restart enable bit positions
    localparam int unsigned AR_EN_LOW_DC = 0;
    localparam int unsigned AR_EN_HIGH_DC = 1;
    localparam int unsigned AR_EN_OVERCURRENT = 2;
    localparam int unsigned AR_EN_HEATSINK = 3;
    localparam int unsigned AR_EN_ANALOG = 4;

    // digital_input_source_select: 0 is source_disabled, 1..6 pick an input line
    localparam logic [2:0] SOURCE_DISABLED = 3'h0;

    // factory values, offered to the parameter store on a factory load
    localparam dfs_resp_t LINK_RESP_RST = RESP_NONE;
    localparam logic [9:0] LINK_TOL_RST_S = 10'h01E;
    localparam dfs_resp_t KEY_RESP_RST = RESP_FAIL;
    localparam logic [8:0] KEY_TOL_RST_S = 9'h01E;
    localparam logic [2:0] EXT_CLR_RST = 3'h4;
    localparam logic [2:0] AR_COUNT_RST = 3'h0;
    localparam logic [13:0] AR_WIN_RST_DS = 14'h0258;
    localparam logic [6:0] AR_DELAY_RST_DS = 7'h0A;
    localparam logic [4:0] AR_ENABLE_RST = 5'h00;

    // access codes after reset; values are arbitrary
    localparam logic [13:0] CODE_MID_RST = 14'h0001;
    localparam logic [13:0] CODE_HIGH_RST = 14'h0002;

    typedef struct packed {
        dfs_resp_t link_resp;
        logic [9:0] link_tol_s;
        dfs_resp_t key_resp;
        logic [8:0] key_tol_s;
        logic [2:0] digital_input_source_select;
        logic [2:0] ar_count;
        logic [13:0] ar_window_ds;
        logic [6:0] ar_delay_ds;
        logic [4:0] ar_enable;
    } dfs_cfg_t;

    typedef struct packed {
        logic valid;
        dfs_field_t field;
        logic [13:0] data;
    } dfs_par_req_t;

    typedef struct packed {
        dfs_fail_t code;
        logic [HOURS_W-1:0] hours;
    } dfs_hist_t;

endpackage : dfs_pkg

`default_nettype wire

// ### dfs_supervisor_properties.sv
/*
 * dfs_supervisor_props: port checks of dfs_supervisor.
 * Assumes one clk_sys_i domain; bound after the module.
 */
`timescale 1ns/1ps
`default_nettype none

module dfs_supervisor_props
    import dfs_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_DS_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire dfs_cfg_t cfg_i,
    input wire logic fail_i,
    input wire dfs_fail_t fail_code_i,
    input wire logic running_i,
    input wire dfs_par_req_t par_req_i,
    input wire logic [FREQ_W-1:0] freq_o,
    input wire logic stop_o,
    input wire logic fault_o,
    input wire dfs_fail_t fault_code_o,
    input wire logic restart_o,
    input wire logic param_lock_o,
    input wire dfs_level_t access_level_o,
    input wire logic par_ack_o,
    input wire logic par_rej_o,
    input wire logic factory_load_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_one_answer: assert property (par_req_i.valid && ce_i |=> par_ack_o != par_rej_o)
        else $error("not one answer");
    a_no_spurious: assert property (ce_i && !par_req_i.valid |=> !par_ack_o && !par_rej_o)
        else $error("answer without request");
    a_lock_rejects: assert property (param_lock_o && par_req_i.valid && ce_i &&
        par_req_i.field inside {[PF_NEW_CODE:PF_OTHER]} |=> par_rej_o)
        else $error("change accepted while locked");
    a_code_range: assert property (par_req_i.valid && ce_i && par_req_i.field == PF_ACCESS &&
        par_req_i.data > CODE_MAX |=> par_rej_o)
        else $error("code above range taken");
    a_access_taken: assert property (par_req_i.valid && ce_i && par_req_i.field == PF_ACCESS &&
        par_req_i.data <= CODE_MAX |=> par_ack_o)
        else $error("code in range refused");
    a_factory_gate: assert property (factory_load_o |-> par_ack_o && !$past(running_i) &&
        $past(access_level_o) == HIGHEST_ACCESS_LEVEL && !$past(param_lock_o))
        else $error("factory load not allowed");
    a_fail_latch: assert property (fail_i && ce_i |=> fault_o && freq_o == '0 &&
        fault_code_o == $past(fail_code_i))
        else $error("failure not latched");
    a_fault_stops: assert property (fault_o |-> stop_o)
        else $error("latched failure without stop");
    a_restart_cause: assert property (restart_o |-> $past(fault_o) && cfg_i.ar_count != 3'h0 &&
        $past(fault_code_o) inside {[FAIL_LOW_DC:FAIL_ANALOG]})
        else $error("restart not eligible");
    a_clear_disabled: assert property (fault_o &&
        cfg_i.digital_input_source_select == SOURCE_DISABLED |=> fault_o || restart_o)
        else $error("cleared while disabled");
endmodule // dfs_supervisor_props

bind dfs_supervisor dfs_supervisor_props #(.TICK_CYC(TICK_CYC)) u_props (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_i(cfg_i), .fail_i(fail_i),
    .fail_code_i(fail_code_i), .running_i(running_i), .par_req_i(par_req_i), .freq_o(freq_o),
    .stop_o(stop_o), .fault_o(fault_o), .fault_code_o(fault_code_o), .restart_o(restart_o),
    .param_lock_o(param_lock_o), .access_level_o(access_level_o), .par_ack_o(par_ack_o),
    .par_rej_o(par_rej_o), .factory_load_o(factory_load_o)
);

`default_nettype wire

// ### testbench.sv
/*
 * testbench: self-checking bench of dfs_supervisor, shortened tick.
 * Assumes dfs_pkg and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import dfs_pkg::*;
;
    logic clk_sys_i, rst_i, ce_i, link_activity_i, key_ref_sel_i, key_present_i, fail_i, running_i;
    logic warn_o, stop_o, fault_o, link_lost_o, key_lost_o, restart_o, param_lock_o;
    logic par_ack_o, par_rej_o, factory_load_o;
    logic [FREQ_W-1:0] ref_freq_i, preset_seven_freq_i, freq_o, fx;
    logic [5:0] din;
    logic [3:0] hist_idx_i;
    dfs_cfg_t cfg_i;
    dfs_fail_t fail_code_i, fault_code_o;
    dfs_par_req_t par_req_i;
    dfs_hist_t hist_o;
    dfs_level_t access_level_o;
    int errors = 0, checks = 0, i;
    integer seed = 32'h0000_ad9f;
    // answer notes: ack, rej, level, lock, factory
    logic [5:0] exp_q[$];

    dfs_supervisor #(.TICK_CYC(10)) uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_i(cfg_i),
        .ref_freq_i(ref_freq_i), .preset_seven_freq_i(preset_seven_freq_i),
        .link_activity_i(link_activity_i), .key_ref_sel_i(key_ref_sel_i),
        .key_present_i(key_present_i), .digital_input_line_i(din), .fail_i(fail_i),
        .fail_code_i(fail_code_i), .running_i(running_i), .par_req_i(par_req_i),
        .hist_idx_i(hist_idx_i), .freq_o(freq_o), .warn_o(warn_o), .stop_o(stop_o),
        .fault_o(fault_o), .fault_code_o(fault_code_o), .link_lost_o(link_lost_o),
        .key_lost_o(key_lost_o), .restart_o(restart_o), .hist_o(hist_o),
        .param_lock_o(param_lock_o), .access_level_o(access_level_o), .par_ack_o(par_ack_o),
        .par_rej_o(par_rej_o), .factory_load_o(factory_load_o)
    );

    task wrap_up();
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task tick();
        @(posedge clk_sys_i);
        #2;
    endtask

    // valid stays up between back-to-back calls
    task par(input dfs_field_t f, input logic [13:0] d, input logic [5:0] e);
        exp_q.push_back(e);
        par_req_i = '{1'b1, f, d};
        tick();
    endtask

    task fl(input dfs_fail_t c);
        fail_code_i = c;
        fail_i = 1'b1;
        tick();
        fail_i = 1'b0;
        ce_i = 1'b0;
        repeat (20) tick();
        ce_i = 1'b1;
        for (i = 0; i < 60 && restart_o !== 1'b1; i++) tick();
    endtask

    // a low sample first gives the rising edge
    task clr(input logic [5:0] p);
        din = 6'h00;
        tick();
        din = p;
        repeat (2) tick();
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        #1;
        if (par_ack_o === 1'b1 || par_rej_o === 1'b1) begin
            if (exp_q.size() == 0) chk("par_extra", 32'h1, 32'h0);
            else chk("par_answer", 32'({par_ack_o, par_rej_o, access_level_o, param_lock_o,
                factory_load_o}), 32'(exp_q.pop_front()));
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        wrap_up();
    end

    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        link_activity_i = 1'b1;
        key_ref_sel_i = 1'b0;
        key_present_i = 1'b0;
        fail_i = 1'b0;
        running_i = 1'b0;
        ref_freq_i = 16'h0000;
        preset_seven_freq_i = 16'h0000;
        din = 6'h00;
        hist_idx_i = 4'h0;
        fail_code_i = FAIL_NONE;
        par_req_i = '0;
        cfg_i = '0;
        cfg_i.link_tol_s = LINK_TOL_RST_S;
        cfg_i.key_resp = RESP_FAIL;
        cfg_i.digital_input_source_select = EXT_CLR_RST;
        cfg_i.ar_window_ds = 14'h0064;
        repeat (8) @(posedge clk_sys_i);
        chk("stop_in_reset", 32'(stop_o), 32'h1);
        #2;
        rst_i = 1'b0;
        tick();
        chk("level_lock", 32'({access_level_o, param_lock_o}), 32'h0);
        par(PF_NEW_CODE, 14'h0005, 6'h10);
        par(PF_ACCESS, 14'h2710, 6'h10);
        par(PF_ACCESS, CODE_HIGH_RST, 6'h28);
        par(PF_NEW_CODE, CODE_MAX, 6'h28);
        par(PF_ACCESS, CODE_HIGH_RST, 6'h20);
        par(PF_ACCESS, CODE_MAX, 6'h28);
        running_i = 1'b1;
        par(PF_FACTORY, 14'h0000, 6'h18);
        running_i = 1'b0;
        par(PF_FACTORY, 14'h0000, 6'h29);
        par(PF_LOCK, 14'h0001, 6'h2A);
        par(PF_NEW_CODE, 14'h0007, 6'h1A);
        par(PF_FACTORY, 14'h0000, 6'h1A);
        par(PF_OTHER, 14'h0000, 6'h1A);
        par(PF_ACCESS, CODE_MID_RST, 6'h26);
        par(PF_LOCK, 14'h0000, 6'h24);
        par(PF_OTHER, 14'h0000, 6'h24);
        for (i = 0; i < 4; i++) par(PF_ACCESS, 14'(100 + {$random(seed)} % 9000), 6'h20);
        par_req_i.valid = 1'b0;
        repeat (2) tick();
        chk("par_pending", 32'(exp_q.size()), 32'h0);
        // two failures back to back, newest first in history
        fail_code_i = FAIL_OVERCURRENT;
        fail_i = 1'b1;
        tick();
        fail_code_i = FAIL_HEATSINK;
        tick();
        fail_i = 1'b0;
        chk("latched", 32'({stop_o, fault_o, fault_code_o}), 32'({2'b11, FAIL_HEATSINK}));
        for (i = 0; i < 3; i++) begin
            hist_idx_i = 4'(i);
            tick();
            chk("hist", 32'(hist_o), 32'({i == 0 ? FAIL_HEATSINK : i == 1 ? FAIL_OVERCURRENT :
                FAIL_NONE, 16'h0000}));
        end
        cfg_i.digital_input_source_select = SOURCE_DISABLED;
        din = 6'h3F;
        repeat (2) tick();
        chk("clear_off", 32'(fault_o), 32'h1);
        cfg_i.digital_input_source_select = EXT_CLR_RST;
        clr(6'h04);
        chk("clear_other_line", 32'(fault_o), 32'h1);
        clr(6'h08);
        chk("clear_on", 32'({fault_o, stop_o}), 32'h0);
        cfg_i.ar_count = 3'h1;
        cfg_i.ar_enable = 5'(1 << AR_EN_OVERCURRENT);
        fl(FAIL_LOW_DC);
        chk("restart_off", 32'(restart_o), 32'h0);
        clr(6'h08);
        fl(FAIL_OVERCURRENT);
        chk("restart_on", 32'({restart_o, fault_o}), 32'h2);
        fl(FAIL_OVERCURRENT);
        chk("restart_budget", 32'({restart_o, fault_o}), 32'h1);
        clr(6'h08);
        fx = 16'($random(seed));
        ref_freq_i = fx;
        preset_seven_freq_i = fx ^ 16'hFFFF;
        cfg_i.link_tol_s = 10'h001;
        cfg_i.link_resp = RESP_WARN;
        link_activity_i = 1'b0;
        repeat (100) tick();
        chk("link_early", 32'(link_lost_o), 32'h0);
        for (i = 0; i < 300 && link_lost_o !== 1'b1; i++) tick();
        repeat (3) tick();
        chk("link_warn", 32'({link_lost_o, warn_o, freq_o}), 32'({2'b11, fx}));
        // thirteen seconds of steady output, then the reference moves
        repeat (1300) tick();
        cfg_i.link_resp = RESP_LAST_AVG;
        ref_freq_i = fx ^ 16'h00FF;
        repeat (3) tick();
        chk("last_avg", 32'({warn_o, freq_o}), 32'({1'b1, fx}));
        cfg_i.link_resp = RESP_PRESET_SEVEN_FREQUENCY_MODE;
        repeat (3) tick();
        chk("preset_seven", 32'(freq_o), 32'(preset_seven_freq_i));
        cfg_i.link_resp = RESP_FAIL;
        repeat (3) tick();
        chk("link_fail", 32'({stop_o, fault_o, fault_code_o}), 32'({2'b11, FAIL_LINK_LOST}));
        chk("key_unwatched", 32'(key_lost_o), 32'h0);
        key_ref_sel_i = 1'b1;
        for (i = 0; i < 300 && key_lost_o !== 1'b1; i++) tick();
        chk("key_lost", 32'(key_lost_o), 32'h1);
        wrap_up();
    end
endmodule // testbench

`default_nettype wire
